// >>> hdl/pdm_ctrl.sv
// Behaviour
// RL1: halt with standby_select 0 enters sleep
// RL2: halt with standby_select 1 enters software standby
// RL3: module standby halts only stopped modules
// RL4: control register 8 bits, select bit 7
// RL5: reserved control bits read zero, written zero
// RL6: mode_pin_reload resamples boot pins on wake-up; code reloads them on standby wake-up only, not on sleep exit
// RL7: low chip_clear_n resets the device
// RL8: NMI or IRQ leaves standby after settling
// RL9: module_stop bit 1 stops that module clock
// RL10: interrupt or reset leaves sleep; reset clears stops
module pdm_ctrl import pdm_pkg::*; #(
    parameter int MODULES = PDM_MODULES,
    parameter int SETTLE_CYCLES = PDM_SETTLE_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic chip_clear_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic halt_exec,
    input wire logic int_accept,
    input wire logic nmi_irq,
    input wire logic [PDM_BOOT_PINS-1:0] boot_mode_pins,
    output logic [PDM_BOOT_PINS-1:0] boot_mode,
    output logic boot_mode_load,
    output logic cpu_halt,
    output logic clock_generator_halt,
    output logic periph_halt,
    output logic [MODULES-1:0] module_clk_en
);
    typedef struct packed {
        pdm_mode_type mode;
        logic [7:0] ctrl;
        logic [MODULES-1:0] stop;
        logic [PDM_BOOT_PINS-1:0] boot;
        logic booted;
        logic boot_load;
        logic cpu_halt;
        logic clk_halt;
        logic [MODULES-1:0] clk_en;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pdm_ctrl_state_type;
    pdm_ctrl_state_type cur_reg;
    pdm_ctrl_state_type cur_next;
    logic rst_all;
    logic settle_start;
    logic settle_done;
    if (MODULES < 1 || MODULES > 32) begin : g_check
        $error("module count must be 1 to 32");
    end
    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [1:0] reg_index(input logic [7:0] addr);
        case (addr)
            PDM_CTRL_OFFSET: reg_index = 2'd0;
            PDM_MSTOP_OFFSET: reg_index = 2'd1;
            PDM_STATUS_OFFSET: reg_index = 2'd2;
            default: reg_index = 2'd3;
        endcase
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[8*i +: 8] = data[8*i +: 8];
            end
        end
    endfunction
    // reset pin low counts as reset
    assign rst_all = reset || !chip_clear_n; // RL7
    ////////////////////////////////////////////////////////////////////////
    // settling timer for standby wake-up
    assign settle_start = (cur_reg.mode == PDM_STANDBY) && nmi_irq; // RL8
    pdm_settle #(.CYCLES(SETTLE_CYCLES)) u_settle (
        .clock(clock),
        .reset(rst_all),
        .start(settle_start),
        .done(settle_done)
    );
    ////////////////////////////////////////////////////////////////////////
    // next state: bus, mode sequencer, clock gating
    always_comb begin
        logic [31:0] rd;
        logic [31:0] wide;
        rd = PDM_READ_ZERO;
        wide = PDM_READ_ZERO;
        cur_next = cur_reg;
        cur_next.boot_load = 1'b0;
        // boot pins caught once after reset release
        if (!cur_reg.booted) begin
            cur_next.boot = boot_mode_pins;
            cur_next.booted = 1'b1;
        end
        // write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            cur_next.aw_held = 1'b1;
            cur_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            cur_next.w_held = 1'b1;
            cur_next.wdata = s_axi_wdata;
            cur_next.wstrb = s_axi_wstrb;
        end
        if (cur_reg.aw_held && cur_reg.w_held) begin
            cur_next.aw_held = 1'b0;
            cur_next.w_held = 1'b0;
            cur_next.bvalid = 1'b1;
            cur_next.bresp = PDM_RESP_OKAY;
            case (reg_index(cur_reg.awaddr))
                2'd0: begin
                    wide = merge({24'h00_0000, cur_reg.ctrl}, cur_reg.wdata, cur_reg.wstrb);
                    cur_next.ctrl = wide[7:0] & PDM_CTRL_WRITABLE; // RL4 RL5
                end
                2'd1: begin
                    wide = merge(32'(cur_reg.stop), cur_reg.wdata, cur_reg.wstrb);
                    cur_next.stop = wide[MODULES-1:0]; // RL9
                end
                2'd2: cur_next.bresp = PDM_RESP_OKAY;
                default: cur_next.bresp = PDM_RESP_SLVERR;
            endcase
        end
        if (cur_reg.bvalid && s_axi_bready) begin
            cur_next.bvalid = 1'b0;
        end
        // read path
        if (s_axi_arvalid && s_axi_arready) begin
            cur_next.rvalid = 1'b1;
            cur_next.rresp = PDM_RESP_OKAY;
            case (reg_index(s_axi_araddr))
                2'd0: rd[7:0] = cur_reg.ctrl & PDM_CTRL_WRITABLE; // RL5
                2'd1: rd[MODULES-1:0] = cur_reg.stop;
                2'd2: begin
                    rd[PDM_STATUS_MODE_LSB +: 2] = 2'(cur_reg.mode);
                    rd[PDM_STATUS_BOOT_LSB +: PDM_BOOT_PINS] = cur_reg.boot;
                end
                default: cur_next.rresp = PDM_RESP_SLVERR;
            endcase
            cur_next.rdata = rd;
        end else if (cur_reg.rvalid && s_axi_rready) begin
            cur_next.rvalid = 1'b0;
        end
        // low-power mode sequencer
        case (cur_reg.mode)
            PDM_RUN: begin
                if (halt_exec) begin
                    if (cur_reg.ctrl[PDM_STANDBY_SELECT_BIT]) begin
                        cur_next.mode = PDM_STANDBY; // RL2
                    end else begin
                        cur_next.mode = PDM_SLEEP; // RL1
                    end
                end
            end
            PDM_SLEEP: begin
                if (int_accept) cur_next.mode = PDM_RUN; // RL10
            end
            PDM_STANDBY: begin
                if (nmi_irq) cur_next.mode = PDM_SETTLE; // RL8
            end
            PDM_SETTLE: begin
                if (settle_done) begin
                    cur_next.mode = PDM_RUN; // RL8
                    if (cur_reg.ctrl[PDM_MODE_PIN_RELOAD_BIT]) begin
                        cur_next.boot = boot_mode_pins; // RL6
                        cur_next.boot_load = 1'b1;
                    end
                end
            end
            default: cur_next.mode = PDM_RUN;
        endcase
        // halt and clock gate outputs follow the next mode
        cur_next.cpu_halt = (cur_next.mode != PDM_RUN); // RL1 RL2
        cur_next.clk_halt = (cur_next.mode == PDM_STANDBY) || (cur_next.mode == PDM_SETTLE); // RL2
        cur_next.clk_en = ~cur_next.stop & {MODULES{!cur_next.clk_halt}}; // RL3 RL9
    end
    ////////////////////////////////////////////////////////////////////////
    // state register; power-on reset clears stops and control
    always_ff @(posedge clock) begin
        if (rst_all) begin
            cur_reg <= '0; // RL7 RL10
            cur_reg.mode <= PDM_RUN;
            cur_reg.ctrl <= PDM_CTRL_RESET; // RL4
            cur_reg.clk_en <= '1;
        end else begin
            cur_reg <= cur_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready = !cur_reg.aw_held && !cur_reg.bvalid;
    assign s_axi_wready = !cur_reg.w_held && !cur_reg.bvalid;
    assign s_axi_bvalid = cur_reg.bvalid;
    assign s_axi_bresp = cur_reg.bresp;
    assign s_axi_arready = !cur_reg.rvalid;
    assign s_axi_rvalid = cur_reg.rvalid;
    assign s_axi_rdata = cur_reg.rdata;
    assign s_axi_rresp = cur_reg.rresp;
    assign boot_mode = cur_reg.boot;
    assign boot_mode_load = cur_reg.boot_load;
    assign cpu_halt = cur_reg.cpu_halt;
    assign clock_generator_halt = cur_reg.clk_halt;
    assign periph_halt = cur_reg.clk_halt;
    assign module_clk_en = cur_reg.clk_en;
    ////////////////////////////////////////////////////////////////////////
    // checks
    localparam int SETTLE_BOUND = SETTLE_CYCLES + 2;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst_all);
    property p_sleep_entry;
        cur_reg.mode == PDM_RUN && halt_exec && !cur_reg.ctrl[PDM_STANDBY_SELECT_BIT]
            |=> cur_reg.mode == PDM_SLEEP && cpu_halt && !clock_generator_halt;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered"); // RL1

    property p_standby_entry;
        cur_reg.mode == PDM_RUN && halt_exec && cur_reg.ctrl[PDM_STANDBY_SELECT_BIT]
            |=> cpu_halt && clock_generator_halt && periph_halt && module_clk_en == '0;
    endproperty
    a_standby_entry: assert property (p_standby_entry) else $error("standby not entered"); // RL2

    property p_module_gate;
        (module_clk_en & cur_reg.stop) == '0 && (periph_halt || module_clk_en == ~cur_reg.stop);
    endproperty
    a_module_gate: assert property (p_module_gate) else $error("module clock gate wrong"); // RL3
    property p_ctrl_reserved;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == PDM_CTRL_OFFSET
            |=> s_axi_rvalid && (s_axi_rdata & ~{24'h00_0000, PDM_CTRL_WRITABLE}) == '0;
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits not zero"); // RL5

    property p_ctrl_write;
        cur_reg.aw_held && cur_reg.w_held && cur_reg.awaddr == PDM_CTRL_OFFSET && cur_reg.wstrb[0]
            |=> cur_reg.ctrl == ($past(cur_reg.wdata[7:0]) & PDM_CTRL_WRITABLE);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // RL4
    sequence s_wake;
        cur_reg.mode == PDM_STANDBY && nmi_irq;
    endsequence
    sequence s_settled;
        cur_reg.mode == PDM_SETTLE && clock_generator_halt;
    endsequence
    property p_standby_exit;
        s_wake |=> s_settled ##[1:SETTLE_BOUND] (cur_reg.mode == PDM_RUN && !cpu_halt);
    endproperty
    a_standby_exit: assert property (p_standby_exit) else $error("standby wake-up wrong"); // RL8

    property p_reload;
        cur_reg.mode == PDM_SETTLE && settle_done
            |=> (boot_mode_load == $past(cur_reg.ctrl[PDM_MODE_PIN_RELOAD_BIT]))
                && (boot_mode == ($past(cur_reg.ctrl[PDM_MODE_PIN_RELOAD_BIT]) ?
                    $past(boot_mode_pins) : $past(boot_mode)));
    endproperty
    a_reload: assert property (p_reload) else $error("boot pin reload wrong"); // RL6

    property p_sleep_exit;
        cur_reg.mode == PDM_SLEEP && int_accept |=> cur_reg.mode == PDM_RUN && !cpu_halt;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left"); // RL10

    property p_stop_write;
        cur_reg.aw_held && cur_reg.w_held && cur_reg.awaddr == PDM_MSTOP_OFFSET && cur_reg.wstrb[0]
            |=> cur_reg.stop[0] == $past(cur_reg.wdata[0]) && (module_clk_en[0] == (!cur_reg.stop[0] && !periph_halt));
    endproperty
    a_stop_write: assert property (p_stop_write) else $error("module stop write wrong"); // RL9

    property p_pin_reset;
        @(posedge clock) disable iff (reset) !chip_clear_n |=> cur_reg.mode == PDM_RUN && cur_reg.stop == '0
            && cur_reg.ctrl == PDM_CTRL_RESET;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored"); // RL7

endmodule

// >>> hdl/pdm_pkg.sv
package pdm_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] PDM_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] PDM_MSTOP_OFFSET = 8'h04;
    localparam logic [7:0] PDM_STATUS_OFFSET = 8'h08;

    // power_down_control fields
    localparam int PDM_STANDBY_SELECT_BIT = 7;
    localparam int PDM_MODE_PIN_RELOAD_BIT = 3;
    localparam logic [7:0] PDM_CTRL_WRITABLE = 8'h88;
    localparam logic [7:0] PDM_CTRL_RESET = 8'h00;

    // status fields
    localparam int PDM_STATUS_MODE_LSB = 0;
    localparam int PDM_STATUS_BOOT_LSB = 2;

    // bus answers
    localparam logic [1:0] PDM_RESP_OKAY = 2'h0;
    localparam logic [1:0] PDM_RESP_SLVERR = 2'h2;
    localparam logic [31:0] PDM_READ_ZERO = 32'h0000_0000;

    // widths
    localparam int PDM_BOOT_PINS = 3;
    localparam int PDM_MODULES = 16;

    // oscillator settling time after a standby wake-up
    localparam int PDM_CLOCK_PERIOD_NS = 4;
    localparam int PDM_SETTLE_TIME_NS = 2000;
    localparam int PDM_SETTLE_CYCLES = (PDM_SETTLE_TIME_NS + PDM_CLOCK_PERIOD_NS - 1) / PDM_CLOCK_PERIOD_NS;

    // low-power mode of the device
    typedef enum logic [1:0] {
        PDM_RUN,
        PDM_SLEEP,
        PDM_STANDBY,
        PDM_SETTLE
    } pdm_mode_type;

endpackage

// >>> hdl/pdm_settle.sv
module pdm_settle import pdm_pkg::*; #(
    parameter int CYCLES = PDM_SETTLE_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    output logic done
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic busy;
        logic [CW-1:0] count;
        logic done;
    } pdm_settle_state_type;

    pdm_settle_state_type cur_reg;
    pdm_settle_state_type cur_next;

    if (CYCLES < 1) begin : g_check
        $error("settle count must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////
    // count out the settling time, one done pulse at the end
    always_comb begin
        cur_next = cur_reg;
        cur_next.done = 1'b0;
        if (start && !cur_reg.busy) begin
            cur_next.busy = 1'b1;
            cur_next.count = '0;
        end else if (cur_reg.busy) begin
            if (cur_reg.count == LAST) begin
                cur_next.busy = 1'b0;
                cur_next.done = 1'b1;
            end else begin
                cur_next.count = cur_reg.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign done = cur_reg.done;

endmodule

// >>> test/pdm_core_model.sv
module pdm_core_model (
    input wire logic clock,
    input wire logic do_halt,
    input wire logic do_int,
    input wire logic do_nmi,
    input wire logic do_clear,
    input wire logic [2:0] pins_value,
    output logic halt_exec,
    output logic int_accept,
    output logic nmi_irq,
    output logic chip_clear_n,
    output logic [2:0] boot_mode_pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // core, interrupt sources and reset pin, each request passed on one cycle later, as wide as it is driven
    initial begin
        halt_exec = 1'b0;
        int_accept = 1'b0;
        nmi_irq = 1'b0;
        chip_clear_n = 1'b1;
    end
    always @(posedge clock) begin
        halt_exec <= do_halt;
        int_accept <= do_int;
        nmi_irq <= do_nmi;
        chip_clear_n <= !do_clear;
    end

    // boot pins are plain levels set by the board
    assign boot_mode_pins = pins_value;
endmodule

// >>> test/tb.sv
module tb;
    import pdm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [1:0] resp;
    } pdm_row_type;

    logic clock, reset, chip_clear_n, halt_exec, int_accept, nmi_irq;
    logic do_halt, do_int, do_nmi, do_clear, load_seen;
    logic [2:0] pins_value, boot_mode_pins, boot_mode;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic boot_mode_load, cpu_halt, clock_generator_halt, periph_halt;
    logic [15:0] module_clk_en;
    integer errors, compares, i, n;
    pdm_row_type rows [0:4];

    pdm_ctrl #(.MODULES(16), .SETTLE_CYCLES(4)) pdm_ctrl_inst (
        .clock(clock), .reset(reset), .chip_clear_n(chip_clear_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .halt_exec(halt_exec), .int_accept(int_accept), .nmi_irq(nmi_irq),
        .boot_mode_pins(boot_mode_pins), .boot_mode(boot_mode), .boot_mode_load(boot_mode_load),
        .cpu_halt(cpu_halt), .clock_generator_halt(clock_generator_halt), .periph_halt(periph_halt),
        .module_clk_en(module_clk_en)
    );

    pdm_core_model pdm_core_model_inst (
        .clock(clock), .do_halt(do_halt), .do_int(do_int), .do_nmi(do_nmi), .do_clear(do_clear),
        .pins_value(pins_value), .halt_exec(halt_exec), .int_accept(int_accept), .nmi_irq(nmi_irq),
        .chip_clear_n(chip_clear_n), .boot_mode_pins(boot_mode_pins)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock and time-zero values
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, do_halt, do_int, do_nmi, do_clear} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        reset = 1'b1;
        pins_value = 3'h2;
        errors = 0;
        compares = 0;
    end

    // catches the one-cycle reload pulse
    always @(posedge clock) begin
        if (reset || do_halt)
            load_seen <= 1'b0;
        else if (boot_mode_load === 1'b1)
            load_seen <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // report and compare
    task automatic summarize;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timed_out;
        errors++;
        $display("FAIL t=%0t wait ran out got %h expected %h", $time, 1'b0, 1'b1);
        summarize();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // bus cycles, entered just after a rising edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        b_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50 && !b_ok; n++) begin
            @(negedge clock);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            r = bresp;
            @(posedge clock);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (b_ok) bready <= 1'b0;
        end
        if (!b_ok) timed_out();
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok, r_ok;
        r_ok = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50 && !r_ok; n++) begin
            @(negedge clock);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (ar_ok) arvalid <= 1'b0;
            if (r_ok) rready <= 1'b0;
        end
        if (!r_ok) timed_out();
    endtask

    // one-cycle request to the core model, then let it settle
    task automatic pulse(input int which);
        if (which == 0) do_halt <= 1'b1;
        if (which == 1) do_int <= 1'b1;
        if (which == 2) do_nmi <= 1'b1;
        @(posedge clock);
        {do_halt, do_int, do_nmi} <= '0;
        repeat (3) @(posedge clock);
    endtask

    task automatic wait_run;
        for (i = 0; i < 100 && cpu_halt !== 1'b0; i++) @(negedge clock);
        if (i == 100) timed_out();
        repeat (2) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rows[0] = '{8'h00, 32'h0000_0088, 32'h0000_0088, PDM_RESP_OKAY};
        rows[1] = '{8'h00, 32'h0000_0008, 32'h0000_0008, PDM_RESP_OKAY};
        rows[2] = '{8'h04, 32'h0000_0005, 32'h0000_0005, PDM_RESP_OKAY};
        rows[3] = '{8'h08, 32'h0000_ffff, 32'h0000_0008, PDM_RESP_OKAY};
        rows[4] = '{8'h0c, 32'h0000_1234, 32'h0000_0000, PDM_RESP_SLVERR};
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        axi_read(8'h00, rd, resp);
        chk(rd, 32'h0000_0000);
        axi_read(8'h04, rd, resp);
        chk(rd, 32'h0000_0000);
        chk({29'h0, boot_mode}, 32'h0000_0002);
        for (int k = 0; k < 5; k++) begin
            axi_write(rows[k].addr, rows[k].wdata, resp);
            chk({30'h0, resp}, {30'h0, rows[k].resp});
            axi_read(rows[k].addr, rd, resp);
            chk(rd, rows[k].rdata);
            chk({30'h0, resp}, {30'h0, rows[k].resp});
        end
        chk({16'h0, module_clk_en}, 32'h0000_fffa);
        // sleep: only the core stops, stopped modules stay stopped
        pulse(0);
        chk({29'h0, cpu_halt, clock_generator_halt, periph_halt}, 32'h0000_0004);
        chk({16'h0, module_clk_en}, 32'h0000_fffa);
        pulse(1);
        chk({31'h0, cpu_halt}, 32'h0000_0000);
        // standby with reload, interrupt accept alone must not wake it
        axi_write(8'h00, 32'h0000_0088, resp);
        pins_value <= 3'h5;
        pulse(0);
        chk({29'h0, cpu_halt, clock_generator_halt, periph_halt}, 32'h0000_0007);
        chk({16'h0, module_clk_en}, 32'h0000_0000);
        pulse(1);
        chk({31'h0, cpu_halt}, 32'h0000_0001);
        pulse(2);
        wait_run();
        chk({29'h0, boot_mode}, 32'h0000_0005);
        chk({31'h0, load_seen}, 32'h0000_0001);
        chk({16'h0, module_clk_en}, 32'h0000_fffa);
        // standby without reload keeps the latched boot mode
        axi_write(8'h00, 32'h0000_0080, resp);
        pins_value <= 3'h6;
        pulse(0);
        pulse(2);
        wait_run();
        chk({29'h0, boot_mode}, 32'h0000_0005);
        chk({31'h0, load_seen}, 32'h0000_0000);
        // reset pin low clears control and module stops
        do_clear <= 1'b1;
        repeat (3) @(posedge clock);
        do_clear <= 1'b0;
        repeat (2) @(posedge clock);
        chk({16'h0, module_clk_en}, 32'h0000_ffff);
        axi_read(8'h00, rd, resp);
        chk(rd, 32'h0000_0000);
        axi_read(8'h04, rd, resp);
        chk(rd, 32'h0000_0000);
        summarize();
    end

    // overall run limit
    initial begin
        #200000;
        timed_out();
    end
endmodule
